//--- bench/prcc_checker.sv
// assertions on the pin, reset and clock ports
`timescale 1ns/10ps
`default_nettype none
module prcc_checker
(
  input wire logic       I_CORE_CLK, I_RST_N, I_RESET_PIN, I_OSC_AMP_INPUT, O_MC_TICK,
  input wire logic       O_COMPARATOR_POS_INPUT, O_COMPARATOR_NEG_INPUT, O_SERIAL_RECEIVE_IN,
  input wire logic       O_EXTERNAL_IRQ_ZERO, O_CPU_CLK_EN, O_PERIPH_CLK_EN,
  input wire logic [3:0] O_MC_PHASE,
  input wire logic [1:0] O_POWER_MODE,
  input wire logic [7:0] I_PORT_ONE_PAD, I_PORT_THREE_PAD, O_PORT_ONE_OE_N,
  input wire logic [7:0] O_PORT_THREE_OE_N, O_PORT_ONE_PULL_EN, O_PORT_THREE_PULL_EN
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [4:0] rise_reg;
  logic       seen_reg;
  // count only in run so a wake or reset never splits a period
  always @(posedge I_CORE_CLK)
    if (!I_RST_N || I_RESET_PIN || O_POWER_MODE != 2'd0)
    begin
      rise_reg <= 5'h00;
      seen_reg <= 1'b0;
    end
    else
    begin
      rise_reg <= O_MC_TICK ? 5'h00 : rise_reg + 5'($rose(I_OSC_AMP_INPUT));
      seen_reg <= seen_reg | O_MC_TICK;
    end
  pull_fixed_a: assert property (
    O_PORT_ONE_PULL_EN == 8'hfc && O_PORT_THREE_PULL_EN == 8'hbf) else $error("pull-ups");
  cmp_only_a: assert property (O_PORT_THREE_OE_N[6]) else $error("bit six driven");
  rst_release_a: assert property (
    I_RESET_PIN |-> (O_PORT_ONE_OE_N & O_PORT_THREE_OE_N) == 8'hff) else $error("pins held");
  cmp_feed_a: assert property (
    {O_COMPARATOR_NEG_INPUT, O_COMPARATOR_POS_INPUT} == I_PORT_ONE_PAD[1:0])
    else $error("comparator feed");
  alt_func_a: assert property (
    {O_EXTERNAL_IRQ_ZERO, O_SERIAL_RECEIVE_IN} == {I_PORT_THREE_PAD[2], I_PORT_THREE_PAD[0]})
    else $error("alternate function");
  mc_len_a: assert property (
    seen_reg && O_MC_TICK |-> rise_reg + 5'($rose(I_OSC_AMP_INPUT)) == 5'd12)
    else $error("machine cycle");
  phase_range_a: assert property (
    O_MC_PHASE < 4'd6 && (!O_MC_TICK || O_MC_PHASE == 4'd0)) else $error("phase count");
  idle_gate_a: assert property (
    O_POWER_MODE == 2'd1 |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN) else $error("idle gating");
  pdown_hold_a: assert property (
    O_POWER_MODE == 2'd2 && !I_RESET_PIN |=> O_POWER_MODE == 2'd2 && !O_PERIPH_CLK_EN)
    else $error("power-down left");
endmodule // prcc_checker
`default_nettype wire

//--- bench/prcc_pins_model.sv
// board side of one port: outside drivers and pull-ups
`timescale 1ns/10ps
`default_nettype none
module prcc_pins_model
#(
  parameter logic [7:0] EXT_PU = 8'h00
)
(
  input  wire logic [7:0] i_oe_n,
  input  wire logic [7:0] i_pull_en,
  input  wire logic [7:0] i_ext_low_n,
  input  wire logic       i_clk,
  output logic      [7:0] o_pad
);
  logic flip_reg = 1'b0;
  // a floating line must not settle to a friendly value
  always @(posedge i_clk) flip_reg <= ~flip_reg;
  assign o_pad = i_oe_n & i_ext_low_n & (i_pull_en | EXT_PU | {8{flip_reg}});
endmodule // prcc_pins_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the pin, reset and clock block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       I_CORE_CLK = 0, I_RST_N = 0, I_RESET_PIN = 0, I_OSC_AMP_INPUT = 0, I_P1_WR = 0;
  logic       I_P3_WR = 0, I_SERIAL_TX_DATA = 1, I_IDLE_REQ = 0, I_PDOWN_REQ = 0;
  logic       I_IRQ_PENDING = 0, I_PROG_MODE = 0, I_PROG_RDATA_EN = 0, I_CMP_RESULT = 0;
  logic       O_OSC_AMP_OUTPUT, O_MC_TICK, O_SFR_RESET, O_CPU_CLK_EN, O_PERIPH_CLK_EN;
  logic       O_COMPARATOR_POS_INPUT, O_COMPARATOR_NEG_INPUT, O_SERIAL_RECEIVE_IN;
  logic       O_EXTERNAL_IRQ_ZERO, O_EXTERNAL_IRQ_ONE, O_TIMER_ZERO_COUNT_IN, O_TIMER_ONE_COUNT_IN;
  logic [1:0] O_POWER_MODE;
  logic [3:0] O_MC_PHASE;
  logic [7:0] I_P1_WDATA = 0, I_P3_WDATA = 0, I_PROG_RDATA = 0, x1 = 8'hff, x3 = 8'hff, d1, d3;
  logic [7:0] O_PORT_ONE_PAD, O_PORT_ONE_OE_N, O_PORT_ONE_PULL_EN, O_PORT_THREE_PAD, O_P1_PINS;
  logic [7:0] O_PORT_THREE_OE_N, O_PORT_THREE_PULL_EN, O_P1_LATCH, O_P3_LATCH, O_P3_PINS;
  logic [7:0] O_PROG_CODE_BYTE, O_PROG_CTRL, e3;
  wire  [7:0] I_PORT_ONE_PAD, I_PORT_THREE_PAD;
  logic [31:0] r;
  int         errors = 0, checked = 0, n, seed = 32'hf5fe;
  prcc_top DUT (.*);
  // bits 0 and 1 of port one lean on board pull-ups
  prcc_pins_model #(.EXT_PU(8'h03)) m_one (.i_oe_n(O_PORT_ONE_OE_N), .i_clk(I_CORE_CLK),
    .i_pull_en(O_PORT_ONE_PULL_EN), .i_ext_low_n(x1), .o_pad(I_PORT_ONE_PAD));
  prcc_pins_model m_three (.i_oe_n(O_PORT_THREE_OE_N), .i_clk(I_CORE_CLK),
    .i_pull_en(O_PORT_THREE_PULL_EN), .i_ext_low_n(x3), .o_pad(I_PORT_THREE_PAD));
  always #4 I_CORE_CLK = ~I_CORE_CLK;
  always @(posedge I_CORE_CLK) I_OSC_AMP_INPUT <= ~I_OSC_AMP_INPUT;
  function automatic logic [7:0] oe3(input logic [7:0] d, input logic t);
    oe3 = d & {6'h3f, t, 1'b1} | 8'h40;
  endfunction
  task automatic cy(input int k);
    repeat (k) @(posedge I_CORE_CLK);
  endtask
  task automatic st(input int k);
    cy(k);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 200)
    begin
      errors++;
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [7:0] a);
    I_P1_WR <= 1;
    I_P1_WDATA <= a;
    cy(1);
    I_P1_WR <= 0;
  endtask
  initial
  begin
    cy(12);
    I_RST_N <= 1;
    st(1);
    chk("p1 latch", O_P1_LATCH, 8'hff);
    chk("p3 oe", O_PORT_THREE_OE_N, 8'hff);
    for (n = 0; n < 200 && O_MC_TICK !== 1'b1; n++) st(1);
    bound(n);
    st(1);
    for (n = 1; n < 200 && O_MC_TICK !== 1'b1; n++) st(1);
    chk("tick period", 8'(n), 8'd24);
    for (int i = 0; i < 24; i++)
    begin
      cy(1);
      r = $random(seed);
      {d1, d3} = (i < 2 || i > 21) ? {16{i[0] ^ (i > 21)}} : r[15:0];
      {x1, x3} <= r[31:16];
      {I_SERIAL_TX_DATA, I_CMP_RESULT, I_PROG_MODE} <= 3'($random(seed));
      {I_P1_WR, I_P3_WR, I_P1_WDATA, I_P3_WDATA} <= {2'b11, d1, d3};
      cy(1);
      {I_P1_WR, I_P3_WR} <= 2'b00;
      st(3);
      chk("p1 latch", O_P1_LATCH, d1);
      chk("p3 latch", O_P3_LATCH, d3);
      chk("p1 oe", O_PORT_ONE_OE_N, d1);
      chk("p3 oe", O_PORT_THREE_OE_N, oe3(d3, I_SERIAL_TX_DATA));
      chk("p1 pins", O_P1_PINS, d1 & x1);
      chk("p3 pins", O_P3_PINS, oe3(d3, I_SERIAL_TX_DATA) & x3 & 8'hbf
        | {1'b0, I_CMP_RESULT, 6'h00});
      chk("prog byte", O_PROG_CODE_BYTE, I_PROG_MODE ? I_PORT_ONE_PAD : 8'h00);
      e3 = oe3(d3, I_SERIAL_TX_DATA) & x3;
      chk("pads low", O_PORT_ONE_PAD | O_PORT_THREE_PAD, 8'h00);
      chk("cmp feed", {6'h00, O_COMPARATOR_NEG_INPUT, O_COMPARATOR_POS_INPUT},
        d1 & x1 & 8'h03);
      chk("alt inputs", {2'b00, O_TIMER_ONE_COUNT_IN, O_TIMER_ZERO_COUNT_IN,
        O_EXTERNAL_IRQ_ONE, O_EXTERNAL_IRQ_ZERO, 1'b0, O_SERIAL_RECEIVE_IN}, e3 & 8'h3d);
      chk("prog ctrl", O_PROG_CTRL & 8'hbf, I_PROG_MODE ? e3 & 8'hbf : 8'h00);
    end
    cy(1);
    {I_PROG_MODE, I_PROG_RDATA_EN, I_PROG_RDATA} <= {2'b11, 8'h5a};
    st(1);
    chk("prog drive", O_PORT_ONE_OE_N, 8'h5a);
    chk("prog read", O_PROG_CODE_BYTE, 8'h5a & x1);
    cy(1);
    {I_PROG_MODE, I_PROG_RDATA_EN} <= 2'b00;
    cy(1);
    I_RESET_PIN <= 1;
    #1;
    chk("pins on reset", O_PORT_ONE_OE_N & O_PORT_THREE_OE_N, 8'hff);
    for (n = 0; n < 200 && O_SFR_RESET !== 1'b1; n++) st(1);
    bound(n);
    chk("reset hold", 8'(n >= 24 && n <= 52), 8'h01);
    cy(1);
    I_RESET_PIN <= 0;
    st(2);
    chk("latch after reset", O_P1_LATCH & O_P3_LATCH, 8'hff);
    chk("reset done", 8'(O_SFR_RESET), 8'h00);
    cy(1);
    wr(8'ha5);
    I_IDLE_REQ <= 1;
    cy(1);
    I_IDLE_REQ <= 0;
    wr(8'h00);
    st(3);
    chk("idle mode", 8'(O_POWER_MODE), 8'h01);
    chk("idle write", O_P1_LATCH, 8'ha5);
    cy(1);
    I_IRQ_PENDING <= 1;
    for (n = 0; n < 200 && O_POWER_MODE !== 2'd0; n++) st(1);
    bound(n);
    cy(1);
    I_IRQ_PENDING <= 0;
    I_PDOWN_REQ <= 1;
    cy(1);
    I_PDOWN_REQ <= 0;
    st(2);
    chk("power-down", {O_POWER_MODE, 5'h00, O_OSC_AMP_OUTPUT}, 8'h81);
    r = 0;
    for (n = 0; n < 60; n++)
    begin
      st(1);
      r = r + O_MC_TICK;
    end
    chk("ticks asleep", r[7:0], 8'h00);
    cy(1);
    I_RESET_PIN <= 1;
    for (n = 0; n < 200 && O_POWER_MODE !== 2'd0; n++) st(1);
    bound(n);
    cy(1);
    I_RESET_PIN <= 0;
    st(4);
    tally_and_finish;
  end
endmodule // tb
bind prcc_top prcc_checker chk_i (.*);
`default_nettype wire

//--- core/prcc_defs.vh
// constants for the port, reset and clock control block
`ifndef PRCC_DEFS_VH
`define PRCC_DEFS_VH
`define PRCC_PORT_RST_VAL    8'hff
`define PRCC_P1_PULLUP_MASK  8'hfc
`define PRCC_P3_CMP_BIT      6
`define PRCC_P3_RXD_BIT      0
`define PRCC_P3_TXD_BIT      1
`define PRCC_P3_IRQ0_BIT     2
`define PRCC_P3_IRQ1_BIT     3
`define PRCC_P3_T0_BIT       4
`define PRCC_P3_T1_BIT       5
`define PRCC_P1_CMP_POS_BIT  0
`define PRCC_P1_CMP_NEG_BIT  1
`define PRCC_OSC_PER_MC      4'd12
`define PRCC_PHASE_PER_MC    4'd6
`define PRCC_RST_HOLD_MC     2'd2
`define PRCC_MODE_RUN        2'd0
`define PRCC_MODE_IDLE       2'd1
`define PRCC_MODE_PDOWN      2'd2
`endif

//--- core/prcc_pin_cell.v
// one quasi-bidirectional port pin cell
`timescale 1ns/10ps
`default_nettype none
module prcc_pin_cell
#(
  parameter HAS_PULLUP = 1
)
(
  input  wire i_latch,
  input  wire i_force_high,
  input  wire i_pad,
  output wire o_pad,
  output wire o_pad_oe_n,
  output wire o_pull_en,
  output wire o_pin_val
);
  // zero latch sinks hard; one leaves only the pull-up
  assign o_pad      = 1'b0;
  assign o_pad_oe_n = i_force_high | i_latch;
  assign o_pull_en  = (HAS_PULLUP != 0) ? 1'b1 : 1'b0;
  assign o_pin_val  = i_pad;
endmodule // prcc_pin_cell
`default_nettype wire

//--- core/prcc_top.v
// port pins, reset sequencing and machine-cycle clocking
// Summary of operation
// - port_one is eight bidirectional pins
// - pull-ups on pins two to seven only
// - pins zero, one feed comparator inputs
// - write one before reading a pin
// - port_three has seven pulled-up bidirectional pins
// - port_three bit six reads comparator in O_P3_PINS; O_PROG_CTRL passes its pad
// - port_three pins carry alternate functions
// - reset releases all pins at once
// - reset held two machine cycles resets
// - twelve oscillator periods per machine cycle
// - oscillator divided by two first
// - idle halts cpu, peripherals keep running
// - power-down stops clock until reset
// - ports carry programming bytes and controls
// - idle ends on interrupt or reset
// - reset keeps ram, reloads registers
`timescale 1ns/10ps
`default_nettype none
`include "prcc_defs.vh"
module prcc_top
(
  input  wire       I_CORE_CLK,
  input  wire       I_RST_N,
  input  wire       I_RESET_PIN,
  input  wire       I_OSC_AMP_INPUT,
  output wire       O_OSC_AMP_OUTPUT,
  input  wire       I_P1_WR,
  input  wire [7:0] I_P1_WDATA,
  input  wire       I_P3_WR,
  input  wire [7:0] I_P3_WDATA,
  input  wire       I_SERIAL_TX_DATA,
  input  wire       I_IDLE_REQ,
  input  wire       I_PDOWN_REQ,
  input  wire       I_IRQ_PENDING,
  input  wire       I_PROG_MODE,
  input  wire [7:0] I_PROG_RDATA,
  input  wire       I_PROG_RDATA_EN,
  input  wire       I_CMP_RESULT,
  input  wire [7:0] I_PORT_ONE_PAD,
  output wire [7:0] O_PORT_ONE_PAD,
  output wire [7:0] O_PORT_ONE_OE_N,
  output wire [7:0] O_PORT_ONE_PULL_EN,
  input  wire [7:0] I_PORT_THREE_PAD,
  output wire [7:0] O_PORT_THREE_PAD,
  output wire [7:0] O_PORT_THREE_OE_N,
  output wire [7:0] O_PORT_THREE_PULL_EN,
  output reg  [7:0] O_P1_LATCH,
  output reg  [7:0] O_P3_LATCH,
  output reg  [7:0] O_P1_PINS,
  output reg  [7:0] O_P3_PINS,
  output wire       O_COMPARATOR_POS_INPUT,
  output wire       O_COMPARATOR_NEG_INPUT,
  output wire       O_SERIAL_RECEIVE_IN,
  output wire       O_EXTERNAL_IRQ_ZERO,
  output wire       O_EXTERNAL_IRQ_ONE,
  output wire       O_TIMER_ZERO_COUNT_IN,
  output wire       O_TIMER_ONE_COUNT_IN,
  output wire [7:0] O_PROG_CODE_BYTE,
  output wire [7:0] O_PROG_CTRL,
  output reg        O_SFR_RESET,
  output reg        O_MC_TICK,
  output reg  [3:0] O_MC_PHASE,
  output wire       O_CPU_CLK_EN,
  output wire       O_PERIPH_CLK_EN,
  output reg  [1:0] O_POWER_MODE
);
  reg  [7:0] p1_latch_reg;
  reg  [7:0] p3_latch_reg;
  reg        osc_div_reg;
  reg        osc_prev_reg;
  reg  [3:0] phase_reg;
  reg  [3:0] phase_next;
  reg  [1:0] rst_mc_reg;
  reg        rst_done_reg;
  reg  [1:0] mode_reg;
  reg  [1:0] mode_next;
  wire       osc_rise;
  wire       mc_end;
  wire [7:0] p1_val;
  wire [7:0] p3_val;
  reg  [7:0] p1_latch_eff;
  reg  [7:0] p3_latch_eff;
  reg  [7:0] p3_read;
  wire       run_osc;

  // pull-up layout of port_one's pins, taken once here from the defs mask; port_three's is decoded in pull_of
  localparam [7:0] p1_pullup_mask = `PRCC_P1_PULLUP_MASK;

  // port_one's comparator pair has no pull-up; port_three lacks one on bit six
  function pull_of;
    input         is_port_three;
    input integer bit_idx;
    begin
      if (is_port_three)
        pull_of = (bit_idx != `PRCC_P3_CMP_BIT);
      else
        pull_of = p1_pullup_mask[bit_idx];
    end
  endfunction

  // power-down freezes the divider, so nothing else advances
  assign run_osc  = (mode_reg != `PRCC_MODE_PDOWN);
  assign osc_rise = I_OSC_AMP_INPUT & ~osc_prev_reg & run_osc;
  assign O_OSC_AMP_OUTPUT = run_osc ? ~I_OSC_AMP_INPUT : 1'b1;

  // a phase is one divided clock, two oscillator periods
  assign mc_end = osc_rise & osc_div_reg & (phase_reg == `PRCC_PHASE_PER_MC - 4'd1);

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      osc_prev_reg <= 1'b0;
      osc_div_reg  <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= I_OSC_AMP_INPUT;
      if (osc_rise)
        osc_div_reg <= ~osc_div_reg;
    end
  end

  always @*
  begin
    phase_next = phase_reg;
    if (osc_rise && osc_div_reg)
      phase_next = mc_end ? 4'd0 : phase_reg + 4'd1;
  end

  // reset pin counted in machine cycles; ram is outside and never touched
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      phase_reg    <= 4'd0;
      rst_mc_reg   <= 2'd0;
      rst_done_reg <= 1'b0;
      O_SFR_RESET  <= 1'b1;
      O_MC_TICK    <= 1'b0;
      O_MC_PHASE   <= 4'd0;
    end
    else
    begin
      phase_reg  <= phase_next;
      O_MC_TICK  <= mc_end;
      O_MC_PHASE <= phase_next;
      if (!I_RESET_PIN)
      begin
        rst_mc_reg   <= 2'd0;
        rst_done_reg <= 1'b0;
        O_SFR_RESET  <= 1'b0;
      end
      else if (mc_end && rst_mc_reg != `PRCC_RST_HOLD_MC)
      begin
        rst_mc_reg <= rst_mc_reg + 2'd1;
        if (rst_mc_reg + 2'd1 == `PRCC_RST_HOLD_MC)
        begin
          rst_done_reg <= 1'b1;
          O_SFR_RESET  <= 1'b1;
        end
      end
    end
  end

  always @*
  begin
    mode_next = mode_reg;
    case (mode_reg)
      `PRCC_MODE_RUN:
        if (I_PDOWN_REQ)
          mode_next = `PRCC_MODE_PDOWN;
        else if (I_IDLE_REQ)
          mode_next = `PRCC_MODE_IDLE;
      `PRCC_MODE_IDLE:
        if (I_IRQ_PENDING || rst_done_reg)
          mode_next = `PRCC_MODE_RUN;
      `PRCC_MODE_PDOWN:
        // oscillator stopped, so the reset pin alone brings it back
        if (I_RESET_PIN)
          mode_next = `PRCC_MODE_RUN;
      default:
        mode_next = `PRCC_MODE_RUN;
    endcase
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      mode_reg     <= `PRCC_MODE_RUN;
      O_POWER_MODE <= `PRCC_MODE_RUN;
    end
    else
    begin
      mode_reg     <= mode_next;
      O_POWER_MODE <= mode_next;
    end
  end

  assign O_CPU_CLK_EN    = (mode_reg == `PRCC_MODE_RUN);
  assign O_PERIPH_CLK_EN = run_osc;

  // latches reload to all ones while the reset pin stands high
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      p1_latch_reg <= `PRCC_PORT_RST_VAL;
      p3_latch_reg <= `PRCC_PORT_RST_VAL;
    end
    else if (I_RESET_PIN || rst_done_reg)
    begin
      p1_latch_reg <= `PRCC_PORT_RST_VAL;
      p3_latch_reg <= `PRCC_PORT_RST_VAL;
    end
    else
    begin
      if (I_P1_WR && O_CPU_CLK_EN)
        p1_latch_reg <= I_P1_WDATA;
      if (I_P3_WR && O_CPU_CLK_EN)
        p3_latch_reg <= I_P3_WDATA;
    end
  end

  // programmer verify path overrides the cpu latch; cpu writes still land underneath
  always @*
  begin
    p1_latch_eff = p1_latch_reg;
    if (I_PROG_MODE && I_PROG_RDATA_EN)
      p1_latch_eff = I_PROG_RDATA;
  end

  // serial transmit shares its pin through the latch; bit six never drives
  always @*
  begin
    p3_latch_eff = p3_latch_reg;
    p3_latch_eff[`PRCC_P3_TXD_BIT] = p3_latch_reg[`PRCC_P3_TXD_BIT]
                                     & I_SERIAL_TX_DATA;
    p3_latch_eff[`PRCC_P3_CMP_BIT] = 1'b1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pins
      // reset pin releases pads combinationally, no clock needed
      prcc_pin_cell #(.HAS_PULLUP(pull_of(1'b0, gi))) u_p1
      (
        .i_latch      (p1_latch_eff[gi]),
        .i_force_high (I_RESET_PIN),
        .i_pad        (I_PORT_ONE_PAD[gi]),
        .o_pad        (O_PORT_ONE_PAD[gi]),
        .o_pad_oe_n   (O_PORT_ONE_OE_N[gi]),
        .o_pull_en    (O_PORT_ONE_PULL_EN[gi]),
        .o_pin_val    (p1_val[gi])
      );
      prcc_pin_cell #(.HAS_PULLUP(pull_of(1'b1, gi))) u_p3
      (
        .i_latch      (p3_latch_eff[gi]),
        .i_force_high (I_RESET_PIN),
        .i_pad        (I_PORT_THREE_PAD[gi]),
        .o_pad        (O_PORT_THREE_PAD[gi]),
        .o_pad_oe_n   (O_PORT_THREE_OE_N[gi]),
        .o_pull_en    (O_PORT_THREE_PULL_EN[gi]),
        .o_pin_val    (p3_val[gi])
      );
    end
  endgenerate

  // bit six of O_P3_PINS reads the comparator, never its pad; O_PROG_CTRL still passes the pad
  always @*
  begin
    p3_read = p3_val;
    p3_read[`PRCC_P3_CMP_BIT] = I_CMP_RESULT;
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      O_P1_LATCH <= `PRCC_PORT_RST_VAL;
      O_P3_LATCH <= `PRCC_PORT_RST_VAL;
      O_P1_PINS  <= `PRCC_PORT_RST_VAL;
      O_P3_PINS  <= `PRCC_PORT_RST_VAL;
    end
    else
    begin
      O_P1_LATCH <= p1_latch_reg;
      O_P3_LATCH <= p3_latch_reg;
      O_P1_PINS  <= p1_val;
      O_P3_PINS  <= p3_read;
    end
  end

  assign O_COMPARATOR_POS_INPUT = I_PORT_ONE_PAD[`PRCC_P1_CMP_POS_BIT];
  assign O_COMPARATOR_NEG_INPUT = I_PORT_ONE_PAD[`PRCC_P1_CMP_NEG_BIT];
  assign O_SERIAL_RECEIVE_IN    = p3_val[`PRCC_P3_RXD_BIT];
  assign O_EXTERNAL_IRQ_ZERO    = p3_val[`PRCC_P3_IRQ0_BIT];
  assign O_EXTERNAL_IRQ_ONE     = p3_val[`PRCC_P3_IRQ1_BIT];
  assign O_TIMER_ZERO_COUNT_IN  = p3_val[`PRCC_P3_T0_BIT];
  assign O_TIMER_ONE_COUNT_IN   = p3_val[`PRCC_P3_T1_BIT];

  // programming: port_one in/out code bytes, port_three control lines
  assign O_PROG_CODE_BYTE = I_PROG_MODE ? p1_val : 8'h00;
  assign O_PROG_CTRL      = I_PROG_MODE ? p3_val : 8'h00;
endmodule // prcc_top
`default_nettype wire
